// ---- hw/rcc_consts.svh ----
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
// What this block does
// - Output driven only while enable bit 15 is 1; enable resets to 0.
// - Source field 14:11 picks port 0 to 3; codes 4 to 15 reserved; reset 0.
// - Frequency field 10:8: 000 25 MHz, 001 125 MHz, 010 31.25 MHz.
// - Level 00 squelches when down, unstable, gig master, 10BASE-T or EEE.
// - Level 01 as 00 but also runs in gig master and 10BASE-T link-up.
// - Level 01 keeps the clock in EEE mode while LP_IDLE is received.
// - Level 10 squelches only when the link is not up.
// - Level 11 never squelches, even with the link down.
// - External squelch pin high squelches the output regardless of settings.
// - Type field 2:0: 000 serial media clock, 001 copper clock; rest reserved.

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define RCC_CTRL_ADDR 8'h18
`define RCC_STAT_ADDR 8'h1c
`define RCC_CTRL_RESET 16'h0000
`define RCC_CTRL_WMASK 16'hff37

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCC_EN_BIT 15
`define RCC_SRC_HI 14
`define RCC_SRC_LO 11
`define RCC_FREQ_HI 10
`define RCC_FREQ_LO 8
`define RCC_SQ_HI 5
`define RCC_SQ_LO 4
`define RCC_TYPE_HI 2
`define RCC_TYPE_LO 0

// ----------------------------------------
// Half-period counts in 250 MHz source edges
// ----------------------------------------
`define RCC_HALF_125 3'h1
`define RCC_HALF_31 3'h4
`define RCC_HALF_25 3'h5
`endif

// ---- hw/rcc_pkg.sv ----
package rcc_pkg;
   typedef enum logic [1:0] {
      RCC_SQ_AUTO = 2'b00,
      RCC_SQ_RELAX = 2'b01,
      RCC_SQ_LINK = 2'b10,
      RCC_SQ_OFF = 2'b11
   } rcc_sq_level_t;

   typedef enum logic [2:0] {
      RCC_F25 = 3'b000,
      RCC_F125 = 3'b001,
      RCC_F31 = 3'b010
   } rcc_freq_t;

   typedef enum logic [2:0] {
      RCC_SERIAL = 3'b000,
      RCC_COPPER = 3'b001
   } rcc_ctype_t;

   typedef enum logic [1:0] {
      RCC_SP10 = 2'b00,
      RCC_SP100 = 2'b01,
      RCC_SP1000 = 2'b10,
      RCC_SPRSV = 2'b11
   } rcc_speed_t;
endpackage

// ---- hw/rcc_squelch.sv ----
`timescale 1ns/1ps
module rcc_squelch import rcc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] level,
   input wire logic enable,
   input wire logic cfg_ok,
   input wire logic link_up,
   input wire logic link_unstable,
   input wire logic [1:0] speed,
   input wire logic gig_master,
   input wire logic eee_active,
   input wire logic lp_idle,
   input wire logic pin,
   output logic squelch
);
   logic next_squelch;
   logic bad_mode;
   logic down;

   always_comb begin
      down = !link_up || link_unstable;
      bad_mode = (speed == RCC_SP10) ||
         ((speed == RCC_SP1000) && gig_master) || (speed == RCC_SPRSV);
      next_squelch = 1'b1;
      unique case (rcc_sq_level_t'(level))
         RCC_SQ_AUTO: next_squelch = down || bad_mode || eee_active;
         RCC_SQ_RELAX: begin
            // Gig master and 10BASE-T allowed, EEE only during LP_IDLE
            next_squelch = down || (speed == RCC_SPRSV) ||
               (eee_active && !lp_idle);
         end
         RCC_SQ_LINK: next_squelch = !link_up;
         RCC_SQ_OFF: next_squelch = 1'b0;
      endcase
      if (pin || !enable || !cfg_ok) begin
         next_squelch = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         squelch <= 1'b1;
      end else begin
         squelch <= next_squelch;
      end
   end
endmodule

// ---- hw/rcc_divider.sv ----
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_divider import rcc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic squelch,
   input wire logic [2:0] freq,
   input wire logic edge_in,
   output logic clk_out
);
   logic [2:0] half;
   logic [2:0] cnt;

   always_comb begin
      unique case (rcc_freq_t'(freq))
         RCC_F25: half = `RCC_HALF_25;
         RCC_F125: half = `RCC_HALF_125;
         RCC_F31: half = `RCC_HALF_31;
         default: half = `RCC_HALF_25;
      endcase
   end

   // Squelch parks the clock low and restarts the phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 3'h0;
         clk_out <= 1'b0;
      end else if (squelch) begin
         cnt <= 3'h0;
         clk_out <= 1'b0;
      end else if (edge_in) begin
         if (cnt == half - 3'h1) begin
            cnt <= 3'h0;
            clk_out <= !clk_out;
         end else begin
            cnt <= cnt + 3'h1;
         end
      end
   end
endmodule

// ---- hw/rcc_top.sv ----
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_top import rcc_pkg::*; #(
   parameter int NUM_PORTS = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [2:0] hburst,
   input wire logic [3:0] hprot,
   input wire logic hmastlock,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [NUM_PORTS-1:0] serial_rclk_edge,
   input wire logic [NUM_PORTS-1:0] copper_rclk_edge,
   input wire logic [NUM_PORTS-1:0] link_up,
   input wire logic [NUM_PORTS-1:0] link_unstable,
   input wire logic [2*NUM_PORTS-1:0] link_speed,
   input wire logic [NUM_PORTS-1:0] gig_master,
   input wire logic [NUM_PORTS-1:0] eee_active,
   input wire logic [NUM_PORTS-1:0] lp_idle_rx,
   input wire logic clk_squelch_in,
   output logic recovered_clock_two_output,
   output logic clock_running
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic pick(input logic [NUM_PORTS-1:0] vec,
                                 input logic [3:0] idx);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (idx == 4'(i)) begin
            r = vec[i];
         end
      end
      return r;
   endfunction

   function automatic logic [1:0] pick2(
      input logic [2*NUM_PORTS-1:0] vec,
      input logic [3:0] idx);
      logic [1:0] r;
      r = 2'b00;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (idx == 4'(i)) begin
            r = vec[2*i +: 2];
         end
      end
      return r;
   endfunction

   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] target);
      return a == target;
   endfunction

   // ----------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_ok;
   logic take_read;
   logic take_write;

   // Only word-aligned accesses with upper address bits clear hit the map
   assign addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);
   assign take_read = hsel && hready && htrans[1] && !hwrite;
   assign take_write = hsel && hready && htrans[1] && hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= take_write && addr_ok;
         wr_addr <= haddr[7:0];
      end
   end

   // Zero wait states, never an error
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;

   always_comb begin
      next_ctrl = ctrl;
      if (wr_pend && addr_is(wr_addr, `RCC_CTRL_ADDR)) begin
         // Reserved bits stay zero whatever is written
         next_ctrl = hwdata[15:0] & `RCC_CTRL_WMASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `RCC_CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   logic cfg_en;
   logic [3:0] cfg_src;
   logic [2:0] cfg_freq;
   logic [1:0] cfg_sq;
   logic [2:0] cfg_type;
   logic src_ok;
   logic freq_ok;
   logic type_ok;
   logic cfg_ok;

   assign cfg_en = ctrl[`RCC_EN_BIT];
   assign cfg_src = ctrl[`RCC_SRC_HI:`RCC_SRC_LO];
   assign cfg_freq = ctrl[`RCC_FREQ_HI:`RCC_FREQ_LO];
   assign cfg_sq = ctrl[`RCC_SQ_HI:`RCC_SQ_LO];
   assign cfg_type = ctrl[`RCC_TYPE_HI:`RCC_TYPE_LO];

   // Reserved codes park the output rather than guess a source
   assign src_ok = cfg_src < 4'(NUM_PORTS);
   assign freq_ok = (cfg_freq == RCC_F25) || (cfg_freq == RCC_F125) ||
      (cfg_freq == RCC_F31);
   assign type_ok = (cfg_type == RCC_SERIAL) ||
      (cfg_type == RCC_COPPER);
   assign cfg_ok = src_ok && freq_ok && type_ok;

   // ----------------------------------------
   // Source selection
   // ----------------------------------------
   logic sel_edge;
   logic sel_up;
   logic sel_unstable;
   logic [1:0] sel_speed;
   logic sel_master;
   logic sel_eee;
   logic sel_lpi;

   always_comb begin
      if (cfg_type == RCC_COPPER) begin
         sel_edge = pick(copper_rclk_edge, cfg_src);
      end else begin
         sel_edge = pick(serial_rclk_edge, cfg_src);
      end
   end

   assign sel_up = pick(link_up, cfg_src);
   assign sel_unstable = pick(link_unstable, cfg_src);
   assign sel_speed = pick2(link_speed, cfg_src);
   assign sel_master = pick(gig_master, cfg_src);
   assign sel_eee = pick(eee_active, cfg_src);
   assign sel_lpi = pick(lp_idle_rx, cfg_src);

   // ----------------------------------------
   // Squelch decision and divider
   // ----------------------------------------
   logic squelch;

   rcc_squelch u_squelch (
      .hclk(hclk),
      .hresetn(hresetn),
      .level(cfg_sq),
      .enable(cfg_en),
      .cfg_ok(cfg_ok),
      .link_up(sel_up),
      .link_unstable(sel_unstable),
      .speed(sel_speed),
      .gig_master(sel_master),
      .eee_active(sel_eee),
      .lp_idle(sel_lpi),
      .pin(clk_squelch_in),
      .squelch(squelch)
   );

   // Edge is delayed one cycle to line up with the registered squelch
   logic edge_d;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edge_d <= 1'b0;
      end else begin
         edge_d <= sel_edge;
      end
   end

   rcc_divider u_divider (
      .hclk(hclk),
      .hresetn(hresetn),
      .squelch(squelch),
      .freq(cfg_freq),
      .edge_in(edge_d),
      .clk_out(recovered_clock_two_output)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_running <= 1'b0;
      end else begin
         clock_running <= !squelch;
      end
   end

   // ----------------------------------------
   // Status register
   // ----------------------------------------
   logic [15:0] status;

   assign status = {8'h00, clk_squelch_in, type_ok, freq_ok, src_ok,
      sel_eee, sel_up, 1'b0, !squelch};

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] next_rdata;

   // Forward the pending write so a read right behind it sees new data
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (take_read && addr_ok) begin
         if (addr_is(haddr[7:0], `RCC_CTRL_ADDR)) begin
            next_rdata = {16'h0000, next_ctrl};
         end else if (addr_is(haddr[7:0], `RCC_STAT_ADDR)) begin
            next_rdata = {16'h0000, status};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         hrdata <= next_rdata;
      end
   end

endmodule

// ---- tb/rcc_top_sva.sv ----
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_top_sva import rcc_pkg::*; #(
   parameter int NUM_PORTS = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [NUM_PORTS-1:0] link_up,
   input wire logic clk_squelch_in,
   input wire logic recovered_clock_two_output,
   input wire logic clock_running
);
   // ----------------------------------------
   // Bus snoop and control shadow
   // ----------------------------------------
   logic a_v, a_w, bad, lk;
   logic [31:0] a_a;
   logic [15:0] sh;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_v <= 1'b0;
         a_w <= 1'b0;
         a_a <= 32'h0;
         sh <= `RCC_CTRL_RESET;
      end else if (hready) begin
         a_v <= hsel && htrans[1];
         a_w <= hwrite;
         a_a <= haddr;
         if (a_v && a_w && a_a == 32'h18) begin
            sh <= hwdata[15:0] & `RCC_CTRL_WMASK;
         end
      end
   end
   // Reserved codes count as a bad setup, like a cleared enable
   assign bad = !sh[15] || sh[14:11] > 4'h3 || sh[10:8] > 3'h2
      || sh[2:0] > 3'h1;
   assign lk = link_up[sh[12:11]];
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_bad;
      bad [*3];
   endsequence
   sequence s_pin;
      clk_squelch_in ##1 clk_squelch_in;
   endsequence
   // Three samples: inputs pass two flops (squelch, then clock_running) before the check
   sequence s_off;
      (!bad && sh[5:4] == 2'b11 && !clk_squelch_in) [*3];
   endsequence
   sequence s_down;
      (!bad && sh[5:4] == 2'b10 && !lk) [*3];
   endsequence
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   AST_NO_WAIT: assert property (hreadyout == 1'b1)
      else $error("hreadyout low");
   AST_CTRL_READ: assert property (
      a_v && !a_w && a_a == 32'h18 |-> hrdata == {16'h0000, sh})
      else $error("control readback wrong");
   AST_UNMAPPED_READ: assert property (
      a_v && !a_w && a_a != 32'h18 && a_a != 32'h1c |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_BAD_CFG: assert property (s_bad |-> !clock_running)
      else $error("clock runs with bad setup");
   AST_PIN_SQUELCH: assert property (s_pin |=> !clock_running)
      else $error("pin did not squelch");
   AST_OUT_LOW: assert property (
      !clock_running |-> !recovered_clock_two_output)
      else $error("output high while squelched");
   AST_LEVEL_OFF: assert property (s_off |-> clock_running)
      else $error("squelched at level off");
   AST_LEVEL_LINK: assert property (s_down |-> !clock_running)
      else $error("runs with link down");
endmodule
bind rcc_top rcc_top_sva #(.NUM_PORTS(NUM_PORTS)) sva_u (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata,
   .hresp, .link_up, .clk_squelch_in, .recovered_clock_two_output,
   .clock_running);

// ---- tb/rcc_clk_sink.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Timing sink: cycles per output half period
// ----------------------------------------
module rcc_clk_sink (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_in,
   output int half_len,
   output int edges
);
   logic last;
   int cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last <= 1'b0;
         cnt <= 0;
         half_len <= 0;
         edges <= 0;
      end else begin
         last <= clk_in;
         if (clk_in != last) begin
            half_len <= cnt + 1;
            cnt <= 0;
            edges <= edges + 1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

// ---- tb/recovered_clock_output_control_test.sv ----
`timescale 1ns/1ps
module recovered_clock_output_control_test import rcc_pkg::*; ;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, csq = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd_q, d;
   logic [1:0] htrans = 0;
   logic [3:0] ser = 4'hf, cop = 0, up = 0, uns = 0, gm = 0, eee = 0, lpi = 0;
   logic [7:0] spd = 0;
   wire hready, hresp, rco, crun;
   wire [31:0] hrdata;
   int errors = 0, samples_checked = 0, half_len, edges, e1;
   always #12.5 hclk = ~hclk;
   // Copper pulses at half the serial rate
   always @(posedge hclk) cop <= ~cop;
   always @(posedge hclk) rd_q <= hrdata;
   rcc_top #(.NUM_PORTS(4)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0),
      .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp,
      .serial_rclk_edge(ser), .copper_rclk_edge(cop), .link_up(up),
      .link_unstable(uns), .link_speed(spd), .gig_master(gm),
      .eee_active(eee), .lp_idle_rx(lpi), .clk_squelch_in(csq),
      .recovered_clock_two_output(rco), .clock_running(crun));
   rcc_clk_sink sink_u (.hclk, .hresetn, .clk_in(rco), .half_len, .edges);
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task xfer(input logic [31:0] a, input logic w, input logic [31:0] v);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
   // Read data comes from a copy taken at the final edge
   task rd(input logic [31:0] a);
      xfer(a, 1'b0, 32'h0);
      @(negedge hclk) d = rd_q;
      @(posedge hclk);
   endtask
   task cfg(input logic [15:0] v);
      xfer(32'h18, 1'b1, {16'h0, v});
      repeat (4) @(posedge hclk);
   endtask
   task run(input logic e);
      @(negedge hclk) chk(crun, e);
      @(posedge hclk);
   endtask
   function logic [15:0] w(input logic [3:0] s, input logic [2:0] f,
      input logic [1:0] q, input logic [2:0] t);
      return {1'b1, s, f, 2'b00, q, 1'b0, t};
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rd(32'h18);
      chk(d, 32'h0);
      run(1'b0);
      cfg(16'hffff);
      rd(32'h18);
      chk(d, 32'h0000ff37);
      run(1'b0);
      rd(32'h40);
      chk(d, 32'h0);
      cfg(w(4'h4, RCC_F125, RCC_SQ_OFF, RCC_SERIAL));
      run(1'b0);
      cfg(w(4'h0, 3'h3, RCC_SQ_OFF, RCC_SERIAL));
      run(1'b0);
      cfg(w(4'h0, RCC_F125, RCC_SQ_OFF, 3'h2));
      run(1'b0);
   endtask
   task t_freq;
      logic [2:0] fq[3];
      int hf[3];
      fq = '{RCC_F25, RCC_F125, RCC_F31};
      hf = '{5, 1, 4};
      for (int i = 0; i < 3; i++) begin
         cfg(w(4'h0, fq[i], RCC_SQ_OFF, RCC_SERIAL));
         run(1'b1);
         repeat (30) @(posedge hclk);
         chk(half_len, hf[i]);
      end
      cfg(w(4'h0, RCC_F125, RCC_SQ_OFF, RCC_COPPER));
      repeat (30) @(posedge hclk);
      chk(half_len, 2);
   endtask
   task t_src;
      up <= 4'b0100;
      for (int p = 0; p < 4; p++) begin
         cfg(w(p[3:0], RCC_F125, RCC_SQ_LINK, RCC_SERIAL));
         run(p == 2);
      end
      rd(32'h1c);
      chk(d, 32'h00000070);
   endtask
   task t_level;
      // {up, unstable, speed, master, eee, lp_idle, want00, want01}
      logic [8:0] tb[8];
      tb = '{9'b1001000_11, 9'b1000000_01, 9'b1010100_01, 9'b1010000_11,
         9'b1001010_00, 9'b1001011_01, 9'b1101000_00, 9'b0001000_00};
      for (int i = 0; i < 8; i++) begin
         {up[0], uns[0], spd[1:0], gm[0], eee[0], lpi[0]} <= tb[i][8:2];
         cfg(w(4'h0, RCC_F125, RCC_SQ_AUTO, RCC_SERIAL));
         run(tb[i][1]);
         cfg(w(4'h0, RCC_F125, RCC_SQ_RELAX, RCC_SERIAL));
         run(tb[i][0]);
      end
      cfg(w(4'h0, RCC_F125, RCC_SQ_LINK, RCC_SERIAL));
      run(1'b0);
      cfg(w(4'h0, RCC_F125, RCC_SQ_OFF, RCC_SERIAL));
      run(1'b1);
   endtask
   task t_pin;
      csq <= 1'b1;
      repeat (4) @(posedge hclk);
      run(1'b0);
      e1 = edges;
      repeat (10) @(posedge hclk);
      chk(edges, e1);
      csq <= 1'b0;
      repeat (4) @(posedge hclk);
      run(1'b1);
      cfg(w(4'h0, RCC_F125, RCC_SQ_OFF, RCC_SERIAL) & 16'h7fff);
      run(1'b0);
   endtask
   initial begin
      #100us;
      errors++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_freq;
      t_src;
      t_level;
      t_pin;
      end_sim;
   end
endmodule
